// ---- verilog/fifo_host_pkg.sv ----
package fifo_host_pkg;
   // ------------------------------------------------------------
   // Widths and depths
   // ------------------------------------------------------------
   localparam int WORD_BITS = 4;
   localparam int STACK_DEPTH = 14;
   localparam int DEVICE_WORDS = 64;
   localparam int BUF_DEPTH = 4;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int STROBE_HALF_NS = 100;
   localparam int STROBE_HALF_CYC =
      (STROBE_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SERIAL_BITS = 4;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;

   typedef struct packed {
      logic [WORD_BITS-1:0] data;
   } word_t;

   typedef enum logic [5:0] {
      IN_IDLE = 6'h01,
      IN_LOAD = 6'h02,
      IN_SHIFT_HI = 6'h04,
      IN_SHIFT_LO = 6'h08,
      IN_WAIT_FULL = 6'h10,
      IN_RELEASE = 6'h20
   } in_state_t;

   typedef enum logic [4:0] {
      OUT_IDLE = 5'h01,
      OUT_REQ = 5'h02,
      OUT_TAKE = 5'h04,
      OUT_SHIFT_HI = 5'h08,
      OUT_SHIFT_LO = 5'h10
   } out_state_t;
endpackage

// ---- verilog/word_buffer.sv ----
`timescale 1ns/1ps
module word_buffer #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("word_buffer depth must be a power of two");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic push, pop;

   always_comb begin
      inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
      outValid = wrPtr != rdPtr;
      push = inValid && inReady;
      pop = outValid && outReady;
      next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
      outData = mem[rdPtr[AW-1:0]];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
      if (push) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule // word_buffer

// ---- verilog/fifo_host_ctrl.sv ----
// Notes on behaviour
// - Host keeps serial-in strobe low in parallel mode, load low in serial.
// - Host keeps serial-out strobe low in parallel extraction; ties serial select.
// - Host holds serial-out strobe low while a new word is loaded.
// - Chained devices give sixty-three words each plus one.
// - Row master ties serial enable low; slaves chain from input-full.
// - Most significant output-empty drives all serial-select inputs in a row.
`timescale 1ns/1ps
module fifo_host_ctrl #(
   parameter int WORD_BITS = fifo_host_pkg::WORD_BITS,
   parameter int BUF_DEPTH = fifo_host_pkg::BUF_DEPTH,
   parameter bit SERIAL_IN = 1'b0,
   parameter bit SERIAL_OUT = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write side from user
   input wire logic wrValid,
   output logic wrReady,
   input wire fifo_host_pkg::word_t wrWord,
   // Read side to user
   output logic rdValid,
   input wire logic rdReady,
   output fifo_host_pkg::word_t rdWord,
   // Device input pins
   output logic parallelLoad,
   output logic serialInStrobe,
   output logic serialInEnable,
   output logic transferToStack,
   output logic masterReset_n,
   output logic [WORD_BITS-1:0] parallelDataIn,
   output logic serialDataIn,
   input wire logic inputFullFlag,
   // Device output pins
   output logic transferOutParallel,
   output logic transferOutSerial,
   output logic serialOutStrobe,
   output logic serialOutEnable,
   input wire logic outputEmptyFlag,
   input wire logic [WORD_BITS-1:0] parallelDataOut,
   input wire logic serialDataOut
);
   initial begin
      if (WORD_BITS != fifo_host_pkg::WORD_BITS) begin
         $error("fifo_host_ctrl word width must match the device");
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [WORD_BITS+2:0] syncA, syncB;
   always_ff @(posedge clk) begin
      syncA <= {inputFullFlag, outputEmptyFlag, serialDataOut, parallelDataOut};
      syncB <= syncA;
   end
   logic fullHigh, emptyHigh, qsBit;
   logic [WORD_BITS-1:0] qWord;
   assign {fullHigh, emptyHigh, qsBit, qWord} = syncB;

   // ------------------------------------------------------------
   // Input buffer
   // ------------------------------------------------------------
   logic bufValid, bufTake;
   logic [WORD_BITS-1:0] bufData;
   word_buffer #(.WIDTH(WORD_BITS), .DEPTH(BUF_DEPTH)) word_buffer_inst (
      .clk(clk),
      .rst(rst),
      .inValid(wrValid),
      .inReady(wrReady),
      .inData(wrWord.data),
      .outValid(bufValid),
      .outReady(bufTake),
      .outData(bufData)
   );

   // ------------------------------------------------------------
   // Strobe pacing, one enable per half period
   // ------------------------------------------------------------
   logic [7:0] divCnt, next_divCnt;
   logic tick;
   always_comb begin
      tick = divCnt == 8'(fifo_host_pkg::STROBE_HALF_CYC - 1);
      next_divCnt = tick ? 8'h00 : divCnt + 8'h01;
   end
   always_ff @(posedge clk) begin
      divCnt <= rst ? 8'h00 : next_divCnt;
   end

   // ------------------------------------------------------------
   // Input side
   // ------------------------------------------------------------
   fifo_host_pkg::in_state_t inState, next_inState;
   logic [WORD_BITS-1:0] inShift, next_inShift;
   logic [2:0] inCnt, next_inCnt;
   logic loadPin, next_loadPin, cpsiPin, next_cpsiPin;

   always_comb begin
      next_inState = inState;
      next_inShift = inShift;
      next_inCnt = inCnt;
      next_loadPin = loadPin;
      next_cpsiPin = cpsiPin;
      bufTake = 1'b0;
      case (inState)
         fifo_host_pkg::IN_IDLE: begin
            // Input-full high means the register is free
            if (tick && fullHigh && bufValid) begin
               bufTake = 1'b1;
               next_inShift = bufData;
               next_inCnt = fifo_host_pkg::BIT_CNT_RESET;
               if (SERIAL_IN) begin
                  next_inState = fifo_host_pkg::IN_SHIFT_HI;
               end else begin
                  next_loadPin = 1'b1;
                  next_inState = fifo_host_pkg::IN_LOAD;
               end
            end
         end
         fifo_host_pkg::IN_LOAD: begin
            if (tick && !fullHigh) begin
               next_inState = fifo_host_pkg::IN_RELEASE;
            end
         end
         fifo_host_pkg::IN_SHIFT_HI: begin
            if (tick) begin
               next_cpsiPin = 1'b1;
               // Data moves on the rising strobe so it is steady at the fall
               if (inCnt != fifo_host_pkg::BIT_CNT_RESET) begin
                  next_inShift = inShift >> 1;
               end
               next_inState = fifo_host_pkg::IN_SHIFT_LO;
            end
         end
         fifo_host_pkg::IN_SHIFT_LO: begin
            if (tick) begin
               // Falling edge counts the bit just sent, LSB first
               next_cpsiPin = 1'b0;
               next_inCnt = inCnt + 3'h1;
               next_inState = (inCnt == 3'(fifo_host_pkg::SERIAL_BITS - 1)) ?
                  fifo_host_pkg::IN_WAIT_FULL : fifo_host_pkg::IN_SHIFT_HI;
            end
         end
         fifo_host_pkg::IN_WAIT_FULL: begin
            if (tick && !fullHigh) begin
               next_inState = fifo_host_pkg::IN_RELEASE;
            end
         end
         fifo_host_pkg::IN_RELEASE: begin
            // Load must drop before the device reinitializes
            if (tick) begin
               next_loadPin = 1'b0;
               next_inState = fifo_host_pkg::IN_IDLE;
            end
         end
         default: next_inState = fifo_host_pkg::IN_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         inState <= fifo_host_pkg::IN_IDLE;
         inShift <= '0;
         inCnt <= fifo_host_pkg::BIT_CNT_RESET;
         loadPin <= 1'b0;
         cpsiPin <= 1'b0;
      end else begin
         inState <= next_inState;
         inShift <= next_inShift;
         inCnt <= next_inCnt;
         loadPin <= next_loadPin;
         cpsiPin <= next_cpsiPin;
      end
   end

   // Strobe stays low during parallel load, load low during serial
   assign parallelLoad = loadPin && !cpsiPin;
   assign serialInStrobe = cpsiPin && !loadPin;
   assign serialInEnable = 1'b0;
   // Automatic entry: transfer as soon as the register is full
   assign transferToStack = fullHigh;
   assign parallelDataIn = inShift;
   assign serialDataIn = inShift[0];
   assign masterReset_n = !rst;

   // ------------------------------------------------------------
   // Output side
   // ------------------------------------------------------------
   fifo_host_pkg::out_state_t outState, next_outState;
   logic topPin, next_topPin, cpsoPin, next_cpsoPin;
   logic [WORD_BITS-1:0] outShift, next_outShift;
   logic [2:0] outCnt, next_outCnt;
   logic holdValid, next_holdValid;
   logic [WORD_BITS-1:0] holdWord, next_holdWord;

   always_comb begin
      next_outState = outState;
      next_topPin = topPin;
      next_cpsoPin = cpsoPin;
      next_outShift = outShift;
      next_outCnt = outCnt;
      next_holdValid = holdValid && !rdReady;
      next_holdWord = holdWord;
      case (outState)
         fifo_host_pkg::OUT_IDLE: begin
            // Only ask for a word when the hold register is empty
            if (tick && !holdValid) begin
               next_topPin = 1'b1;
               next_outState = fifo_host_pkg::OUT_REQ;
            end
         end
         fifo_host_pkg::OUT_REQ: begin
            if (tick && emptyHigh) begin
               if (SERIAL_OUT) begin
                  next_topPin = 1'b0;
                  next_outCnt = fifo_host_pkg::BIT_CNT_RESET;
                  next_outShift = '0;
                  next_outState = fifo_host_pkg::OUT_SHIFT_HI;
               end else begin
                  next_holdWord = qWord;
                  next_outState = fifo_host_pkg::OUT_TAKE;
               end
            end
         end
         fifo_host_pkg::OUT_TAKE: begin
            if (tick) begin
               next_topPin = 1'b0;
               next_holdValid = 1'b1;
               next_outState = fifo_host_pkg::OUT_IDLE;
            end
         end
         fifo_host_pkg::OUT_SHIFT_HI: begin
            if (tick) begin
               next_outShift = {qsBit, outShift[WORD_BITS-1:1]};
               next_cpsoPin = 1'b1;
               next_outState = fifo_host_pkg::OUT_SHIFT_LO;
            end
         end
         fifo_host_pkg::OUT_SHIFT_LO: begin
            if (tick) begin
               next_cpsoPin = 1'b0;
               next_outCnt = outCnt + 3'h1;
               if (outCnt == 3'(fifo_host_pkg::SERIAL_BITS - 1)) begin
                  next_holdWord = outShift;
                  next_holdValid = 1'b1;
                  next_outState = fifo_host_pkg::OUT_IDLE;
               end else begin
                  next_outState = fifo_host_pkg::OUT_SHIFT_HI;
               end
            end
         end
         default: next_outState = fifo_host_pkg::OUT_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         outState <= fifo_host_pkg::OUT_IDLE;
         topPin <= 1'b0;
         cpsoPin <= 1'b0;
         outShift <= '0;
         outCnt <= fifo_host_pkg::BIT_CNT_RESET;
         holdValid <= 1'b0;
         holdWord <= '0;
      end else begin
         outState <= next_outState;
         topPin <= next_topPin;
         cpsoPin <= next_cpsoPin;
         outShift <= next_outShift;
         outCnt <= next_outCnt;
         holdValid <= next_holdValid;
         holdWord <= next_holdWord;
      end
   end

   assign transferOutParallel = topPin;
   // Single device: serial select low, strobe low while loading
   assign transferOutSerial = 1'b0;
   assign serialOutStrobe = cpsoPin && !topPin;
   assign serialOutEnable = 1'b0;
   assign rdValid = holdValid;
   assign rdWord.data = holdWord;
endmodule // fifo_host_ctrl

// ---- dv/fifo_host_ctrl_props.sv ----
`timescale 1ns/1ps
module fifo_host_ctrl_props #(
   parameter int WORD_BITS = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Read side
   input wire logic rdValid,
   input wire fifo_host_pkg::word_t rdWord,
   // Device pins
   input wire logic parallelLoad,
   input wire logic serialInStrobe,
   input wire logic serialInEnable,
   input wire logic inputFullFlag,
   input wire logic transferOutParallel,
   input wire logic transferOutSerial,
   input wire logic serialOutStrobe,
   input wire logic outputEmptyFlag,
   input wire logic [WORD_BITS-1:0] parallelDataOut
);
   // ----------------------------------------
   // Pin discipline toward the device
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_LOAD_NO_STROBE: assert property (parallelLoad |-> !serialInStrobe)
      else $error("serial strobe during parallel load");
   AST_IES_LOW: assert property (!serialInEnable)
      else $error("serial enable not low");
   AST_TOS_LOW: assert property (!transferOutSerial)
      else $error("serial select not low");
   AST_SOUT_QUIET:
      assert property (transferOutParallel |-> !serialOutStrobe)
      else $error("serial out strobe during word load");
   AST_LOAD_START: assert property ($rose(parallelLoad) |-> inputFullFlag)
      else $error("load raised while register full");
   // Dropping load early would let the device skip reinit
   AST_LOAD_RELEASE:
      assert property ($fell(parallelLoad) |-> !$past(inputFullFlag, 4))
      else $error("load dropped before full flag seen");
   AST_TOP_END:
      assert property ($fell(transferOutParallel) |-> outputEmptyFlag)
      else $error("transfer out dropped with no word taken");
   AST_WORD_HELD:
      assert property ($rose(rdValid) |-> rdWord.data == parallelDataOut)
      else $error("read word differs from device outputs");
endmodule // fifo_host_ctrl_props
bind fifo_host_ctrl fifo_host_ctrl_props #(.WORD_BITS(WORD_BITS)) fifo_host_ctrl_props_inst (.*);

// ---- dv/fall_through_model.sv ----
`timescale 1ns/1ps
module fall_through_model #(
   parameter int FALL_CYC = 20
) (
   // Sampling clock
   input wire logic clk,
   // Input side pins
   input wire logic parallelLoad,
   input wire logic serialInStrobe,
   input wire logic serialInEnable,
   input wire logic transferToStack,
   input wire logic masterReset_n,
   input wire logic [3:0] parallelDataIn,
   input wire logic serialDataIn,
   output logic inputFullFlag,
   // Output side pins
   input wire logic transferOutParallel,
   input wire logic transferOutSerial,
   input wire logic serialOutStrobe,
   input wire logic serialOutEnable,
   output logic outputEmptyFlag,
   output logic [3:0] parallelDataOut,
   output logic serialDataOut
);
   // ----------------------------------------
   // Parallel paths only; serial pins unused
   // ----------------------------------------
   logic [3:0] stack [$];
   logic [3:0] inReg;
   logic inFull = 1'b0;
   logic initDone = 1'b0;
   logic outFull = 1'b0;
   int fall = 0;
   assign inputFullFlag = !inFull;
   assign outputEmptyFlag = outFull;
   initial serialDataOut = 1'b0;
   always @(posedge clk) begin
      // Released line moves each cycle, never shows the last bit
      serialDataOut <= !serialDataOut;
      if (!masterReset_n) begin
         inFull <= 1'b0;
         initDone <= 1'b0;
         outFull <= 1'b0;
         fall <= 0;
         stack.delete();
      end else begin
         if (parallelLoad) begin
            inReg <= parallelDataIn;
            inFull <= 1'b1;
         end
         if (!transferToStack && inFull && !initDone && stack.size() < 14) begin
            stack.push_back(inReg);
            initDone <= 1'b1;
         end
         if (initDone && !parallelLoad) begin
            inFull <= 1'b0;
            initDone <= 1'b0;
         end
         fall <= (stack.size() == 0) ? 0 : fall + 1;
         if (!transferOutParallel) begin
            outFull <= 1'b0;
         end else if (!outFull && stack.size() > 0 && fall >= FALL_CYC) begin
            parallelDataOut <= stack.pop_front();
            outFull <= 1'b1;
            fall <= 0;
         end
      end
   end
endmodule // fall_through_model

// ---- dv/fifo_host_ctrl_test.sv ----
`timescale 1ns/1ps
module fifo_host_ctrl_test;
   typedef struct packed {
      logic [3:0] din;
      logic [3:0] dout;
   } row_t;
   localparam int LIMIT = 40000;
   row_t rows [8] = '{8'h00, 8'hFF, 8'h55, 8'hAA, 8'h11, 8'h88, 8'h77, 8'hEE};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wrValid = 1'b0;
   logic rdReady = 1'b0;
   fifo_host_pkg::word_t wrWord = 4'h0;
   fifo_host_pkg::word_t rdWord;
   logic wrReady, rdValid, parallelLoad, serialInStrobe, serialInEnable, transferToStack;
   logic masterReset_n, serialDataIn, inputFullFlag, transferOutParallel, transferOutSerial;
   logic serialOutStrobe, serialOutEnable, outputEmptyFlag, serialDataOut;
   logic [3:0] parallelDataIn, parallelDataOut;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   fifo_host_ctrl fifo_host_ctrl_inst (.*);
   fall_through_model fall_through_model_inst (.*);
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         close_out();
      end
   end
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_word(input string what, input fifo_host_pkg::word_t exp,
         input fifo_host_pkg::word_t got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(input logic [3:0] w);
      @(posedge clk);
      wrValid <= 1'b1;
      wrWord <= w;
      do @(negedge clk); while (wrReady !== 1'b1);
      @(posedge clk);
      wrValid <= 1'b0;
   endtask
   task automatic get(input logic [3:0] exp);
      fifo_host_pkg::word_t got;
      @(posedge clk);
      rdReady <= 1'b1;
      do @(negedge clk); while (rdValid !== 1'b1);
      got = rdWord;
      @(posedge clk);
      rdReady <= 1'b0;
      check_word("rdWord", exp, got);
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk);
      check_bit("masterReset_n", 1'b0, masterReset_n);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      check_bit("inputFullFlag", 1'b1, inputFullFlag);
      check_bit("outputEmptyFlag", 1'b0, outputEmptyFlag);
      foreach (rows[i]) begin
         put(rows[i].din);
         get(rows[i].dout);
      end
      // Far side stalls until stack and buffer refuse more words
      fork
         for (int i = 0; i < 24; i++) put(i[3:0]);
         begin
            repeat (3000) @(negedge clk);
            check_bit("wrReady", 1'b0, wrReady);
            check_bit("inputFullFlag", 1'b0, inputFullFlag);
            for (int i = 0; i < 24; i++) get(i[3:0]);
         end
      join
      // Reset in mid-run must leave no stale word behind
      put(4'h3);
      repeat (300) @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      check_bit("rdValid", 1'b0, rdValid);
      put(4'hC);
      get(4'hC);
      close_out();
   end
endmodule // fifo_host_ctrl_test
